// ### hw/sltpg_pkg.sv
// package of constants and types for the serial link test pattern generator
package sltpg_pkg;

   // ==========================================
   // lane geometry
   localparam int unsigned NUM_LANES  = 8;
   localparam int unsigned OCT_W      = 8;
   localparam int unsigned MODE_W     = 4;
   localparam int unsigned OCT_IDX_W  = 4;

   // ==========================================
   // link mode indices and frame lengths in octets
   localparam logic [3:0] LINK_MODE_12 = 4'h0_00C;
   localparam logic [3:0] LINK_MODE_13 = 4'h0_00D;
   localparam logic [3:0] LINK_MODE_14 = 4'h0_00E;
   localparam logic [3:0] LINK_MODE_15 = 4'h0_00F;
   localparam logic [3:0] FRAME_LEN_M12 = 4'h0_001;
   localparam logic [3:0] FRAME_LEN_M13 = 4'h0_005;
   localparam logic [3:0] FRAME_LEN_M14 = 4'h0_003;
   localparam logic [3:0] FRAME_LEN_OTH = 4'h0_001;

   // ==========================================
   // pattern values
   localparam logic [7:0]  MODE12_BASE_LO = 8'h0_1;
   localparam logic [7:0]  MODE12_BASE_HI = 8'h1_1;
   localparam logic [11:0] MODE13_BASE    = 12'h30_1;
   localparam logic [11:0] MODE13_STEP    = 12'h0F_0;
   localparam logic [11:0] MODE13_HALF    = 12'h34_1;
   localparam logic [11:0] MODE14_BASE    = 12'hF0_1;
   localparam logic [11:0] MODE14_STEP    = 12'h0F_0;
   localparam logic [7:0]  CHAR_D21_5     = 8'hB_5;
   localparam logic [7:0]  CHAR_K28_5     = 8'hB_C;
   localparam logic [3:0]  RPAT_LEN       = 4'h0_00C;

   // ==========================================
   // 12-octet rpat encoder input sequence
   localparam logic [7:0] RPAT_SEQ [12] = '{8'hB_E, 8'hD_7, 8'h2_3, 8'h4_7, 8'h6_B, 8'h8_F,
                                            8'hB_3, 8'h1_4, 8'h5_E, 8'hF_B, 8'h3_5, 8'h5_9};

   // ==========================================
   // test mode select and link state
   typedef enum logic [2:0] {
      SLTPG_NORMAL, SLTPG_SHORT_TP, SLTPG_D21_5, SLTPG_K28_5, SLTPG_REP_ILA, SLTPG_RPAT
   } sltpg_test_e;

   typedef enum logic [1:0] { SLTPG_CGS, SLTPG_ILA, SLTPG_DATA } sltpg_link_e;

endpackage : sltpg_pkg

// ### hw/sltpg_pattern_rom.sv
// per-lane short transport pattern octet lookup
module sltpg_pattern_rom
   import sltpg_pkg::*;
(
   // selection
   input  wire logic [MODE_W-1:0]    link_mode_index,
   input  wire logic [2:0]           lane,
   input  wire logic [OCT_IDX_W-1:0] oct_idx,
   // result
   output logic      [OCT_W-1:0]     octet
);

   // ==========================================
   // word builders
   function automatic logic [11:0] word13(input logic [2:0] ln, input logic [1:0] w);
      logic [11:0] base;
      base = ln[2] ? MODE13_HALF : MODE13_BASE;
      word13 = base - 12'(ln[1:0]) * MODE13_STEP + 12'(w);
   endfunction

   logic [11:0] w0, w1, w2, w3, a0, a1;
   logic [39:0] f13;
   logic [23:0] f14;

   always_comb
   begin
      w0 = word13(lane, 2'd0);
      w1 = word13(lane, 2'd1);
      w2 = word13(lane, 2'd2);
      w3 = word13(lane, 2'd3);
      // four words packed
      // ten bits a word: five octets hold no more, and every value is below 0x400
      f13 = {w0[9:0], w1[9:0], w2[9:0], w3[9:0]};
      a0 = MODE14_BASE - 12'(lane) * MODE14_STEP;
      a1 = a0 + 12'h00_1;
      f14 = {a0, a1};
      octet = '0;
      case (link_mode_index)
         LINK_MODE_12: octet = (lane[2] ? MODE12_BASE_HI : MODE12_BASE_LO) + 8'(lane[1:0]);
         LINK_MODE_13: octet = f13[39 - 8*oct_idx[2:0] -: 8];
         LINK_MODE_14, LINK_MODE_15: octet = f14[23 - 8*oct_idx[1:0] -: 8];
         default: octet = '0;
      endcase
   end

endmodule // sltpg_pattern_rom

// ### hw/sltpg_gen.sv
// test pattern source for the eight-lane transmit link
// How it works
// - each short pattern repeats identically every frame on every lane
// - mode 12: one octet per lane, 0x01..0x04 then 0x11..0x14
// - mode 13: every lane carries four 10-bit words in five octets
// - mode 14: lane n words 0xF01 minus n*0x0F0, and one more
// - mode 15 sends the same pattern as mode 14
// - alternating-bit test sends D21.5 on all lanes, any encoding
// - comma test sends K28.5 on all lanes, 8b/10b only
// - repeated ila test loops alignment sequence, never enters data
// - sync request restarts code group sync, then ila repeats again
// - rpat sends a 12-octet cycle into the encoder, 8b/10b only
// - rpat octets 0xBE..0x59 in order, wrapping to octet 0
module sltpg_gen
   import sltpg_pkg::*;
(
   // clock and reset
   input  wire logic                       core_clk,
   input  wire logic                       rst_b,
   input  wire logic                       clk_en,
   // configuration
   input  wire logic [MODE_W-1:0]          link_mode_index,
   input  wire sltpg_test_e                test_sel,
   input  wire logic                       enc_8b10b,
   input  wire logic [3:0]                 ila_len,
   // link control
   input  wire logic                       sync_req,
   // sample path
   input  wire logic [NUM_LANES*OCT_W-1:0] sample_data,
   // lane outputs
   output logic      [NUM_LANES*OCT_W-1:0] lane_data,
   output logic      [NUM_LANES-1:0]       lane_is_ctrl,
   output sltpg_link_e                     link_state,
   output sltpg_test_e                     active_test
);

   // ==========================================
   // frame position
   logic [OCT_IDX_W-1:0] oct_idx;
   logic [OCT_IDX_W-1:0] frame_len;
   logic [3:0]           rpat_idx;
   logic [3:0]           ila_cnt;
   logic                 frame_end;
   logic [NUM_LANES*OCT_W-1:0] next_lane_data;
   logic [NUM_LANES-1:0]       next_ctrl;
   logic [NUM_LANES*OCT_W-1:0] rom_out;

   always_comb
   begin
      case (link_mode_index)
         LINK_MODE_12: frame_len = FRAME_LEN_M12;
         LINK_MODE_13: frame_len = FRAME_LEN_M13;
         LINK_MODE_14, LINK_MODE_15: frame_len = FRAME_LEN_M14;
         default: frame_len = FRAME_LEN_OTH;
      endcase
   end

   // a shorter new mode must not wait for the counter to wrap
   assign frame_end = (oct_idx >= frame_len - 4'h0_001);

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         oct_idx <= '0;
      else if (clk_en)
         oct_idx <= frame_end ? '0 : oct_idx + 4'h0_001;
   end

   // ==========================================
   // test select latch
   // frame boundary update
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         active_test <= SLTPG_NORMAL;
      else if (clk_en && frame_end)
         active_test <= test_sel;
   end

   // ==========================================
   // link state for repeated ila
   // sync restarts cgs
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         link_state <= SLTPG_CGS;
         ila_cnt    <= '0;
      end
      else if (clk_en)
      begin
         if (sync_req)
         begin
            link_state <= SLTPG_CGS;
            ila_cnt    <= '0;
         end
         else
            case (link_state)
               SLTPG_CGS:
                  if (frame_end)
                     link_state <= SLTPG_ILA;
               SLTPG_ILA:
                  if (frame_end)
                  begin
                     if (ila_cnt == ila_len && active_test != SLTPG_REP_ILA)
                        link_state <= SLTPG_DATA;
                     ila_cnt <= (ila_cnt == ila_len) ? '0 : ila_cnt + 4'h0_001;
                  end
               SLTPG_DATA: link_state <= SLTPG_DATA;
               default: link_state <= SLTPG_CGS;
            endcase
      end
   end

   // ==========================================
   // rpat index
   // wrap after octet 11
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         rpat_idx <= '0;
      else if (clk_en)
         rpat_idx <= (rpat_idx == RPAT_LEN - 4'h0_001) ? '0 : rpat_idx + 4'h0_001;
   end

   // ==========================================
   // per-lane pattern lookup
   genvar g;
   generate
      for (g = 0; g < NUM_LANES; g++)
      begin : g_lane
         sltpg_pattern_rom u_rom (
            .link_mode_index (link_mode_index),
            .lane            (3'(g)),
            .oct_idx         (oct_idx),
            .octet           (rom_out[g*OCT_W +: OCT_W])
         );
      end
   endgenerate

   // ==========================================
   // output select
   always_comb
   begin
      next_lane_data = sample_data;
      next_ctrl      = '0;
      case (active_test)
         SLTPG_NORMAL: next_lane_data = sample_data;
         SLTPG_SHORT_TP: next_lane_data = rom_out;
         SLTPG_D21_5: next_lane_data = {NUM_LANES{CHAR_D21_5}};
         SLTPG_K28_5:
         begin
            next_lane_data = enc_8b10b ? {NUM_LANES{CHAR_K28_5}} : sample_data;
            next_ctrl      = enc_8b10b ? '1 : '0;
         end
         SLTPG_REP_ILA:
         begin
            // link layer frames the ila; cgs sends commas here
            next_lane_data = (link_state == SLTPG_CGS) ? {NUM_LANES{CHAR_K28_5}} : sample_data;
            next_ctrl      = (link_state == SLTPG_CGS) ? '1 : '0;
         end
         SLTPG_RPAT: next_lane_data = enc_8b10b ? {NUM_LANES{RPAT_SEQ[rpat_idx]}} : sample_data;
         default: next_lane_data = sample_data;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lane_data    <= '0;
         lane_is_ctrl <= '0;
      end
      else if (clk_en)
      begin
         lane_data    <= next_lane_data;
         lane_is_ctrl <= next_ctrl;
      end
   end

   // ==========================================
   // assertions
   a_d21_stream: assert property (@(posedge core_clk) disable iff (!rst_b)
      clk_en && active_test == SLTPG_D21_5 |=> lane_data == {NUM_LANES{CHAR_D21_5}})
      else $error("d21.5 stream broken");
   a_k28_stream: assert property (@(posedge core_clk) disable iff (!rst_b)
      clk_en && active_test == SLTPG_K28_5 && enc_8b10b |=> lane_data[7:0] == CHAR_K28_5 && lane_is_ctrl == '1)
      else $error("k28.5 stream broken");
   a_ila_never_data: assert property (@(posedge core_clk) disable iff (!rst_b)
      link_state != SLTPG_DATA && active_test == SLTPG_REP_ILA && $stable(active_test) |=> link_state != SLTPG_DATA)
      else $error("repeated ila entered data");
   a_sync_restart: assert property (@(posedge core_clk) disable iff (!rst_b)
      clk_en && sync_req |=> link_state == SLTPG_CGS)
      else $error("sync request did not restart cgs");
   a_rpat_wrap: assert property (@(posedge core_clk) disable iff (!rst_b)
      clk_en && rpat_idx == 4'h0_00B |=> rpat_idx == '0)
      else $error("rpat did not wrap");
   a_sel_boundary: assert property (@(posedge core_clk) disable iff (!rst_b)
      !(clk_en && frame_end) |=> $stable(active_test))
      else $error("test select changed mid frame");
   a_m12_lane7: assert property (@(posedge core_clk) disable iff (!rst_b)
      clk_en && active_test == SLTPG_SHORT_TP && link_mode_index == LINK_MODE_12 |=> lane_data[63:56] == 8'h1_4)
      else $error("mode 12 lane 7 wrong");
   a_m14_lane0: assert property (@(posedge core_clk) disable iff (!rst_b)
      clk_en && active_test == SLTPG_SHORT_TP && link_mode_index == LINK_MODE_14 && oct_idx == '0
      |=> lane_data[7:0] == 8'hF_0)
      else $error("mode 14 lane 0 wrong");

   sequence s_short_start(logic [3:0] md);
      clk_en && active_test == SLTPG_SHORT_TP && link_mode_index == md && oct_idx == '0;
   endsequence
   sequence s_m12_short;
      clk_en && active_test == SLTPG_SHORT_TP && link_mode_index == LINK_MODE_12;
   endsequence

   a_frame_repeat: assert property (@(posedge core_clk) disable iff (!rst_b)
      s_m12_short ##1 s_m12_short |=> $stable(lane_data))
      else $error("short pattern changed between frames");
   a_m13_lane0: assert property (@(posedge core_clk) disable iff (!rst_b)
      s_short_start(LINK_MODE_13) |=> lane_data[7:0] == 8'hC_0)
      else $error("mode 13 lane 0 wrong");
   a_m13_lane4: assert property (@(posedge core_clk) disable iff (!rst_b)
      s_short_start(LINK_MODE_13) |=> lane_data[39:32] == 8'hD_0)
      else $error("mode 13 lane 4 wrong");
   a_m15_lane7: assert property (@(posedge core_clk) disable iff (!rst_b)
      s_short_start(LINK_MODE_15) |=> lane_data[63:56] == 8'h8_7)
      else $error("mode 15 lane 7 wrong");
   a_rpat_start: assert property (@(posedge core_clk) disable iff (!rst_b)
      clk_en && active_test == SLTPG_RPAT && enc_8b10b && rpat_idx == '0 |=> lane_data[63:56] == RPAT_SEQ[0])
      else $error("rpat first octet wrong");

endmodule // sltpg_gen

// ### testbench/sltpg_rx_model.sv
// receiver-side partner model that raises synchronization requests
module sltpg_rx_model
(
   // clock and reset
   input  wire logic core_clk,
   input  wire logic rst_b,
   // command from the bench
   input  wire logic want_sync,
   // link control
   output logic      sync_req
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================
   // request logic
   // request while commanded
   // a real receiver also requests out of reset, so we do too
   always_ff @(posedge core_clk or negedge rst_b)
      if (!rst_b)
         sync_req <= 1'b1;
      else
         sync_req <= want_sync;
endmodule // sltpg_rx_model

// ### testbench/serial_link_test_pattern_gen_tb.sv
// self-checking bench for the test pattern generator
`define CHK(a, b) chk(64'(a), 64'(b))
module serial_link_test_pattern_gen_tb
   import sltpg_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        core_clk = 0, rst_b = 0, clk_en = 1, enc_8b10b = 1, want_sync = 0, sync_req;
   logic [3:0]  link_mode_index = 4'h000C, ila_len = 4'h0002;
   sltpg_test_e test_sel = SLTPG_NORMAL, active_test;
   sltpg_link_e link_state;
   logic [63:0] sample_data = '0, lane_data, prev;
   logic [7:0]  lane_is_ctrl;
   logic [11:0] w;
   logic [39:0] f40;
   logic [31:0] lfsr = 32'h0000_7F64;
   logic [7:0]  frm [8][$];
   logic [7:0]  rpat [$] = '{8'hBE, 8'hD7, 8'h23, 8'h47, 8'h6B, 8'h8F, 8'hB3, 8'h14, 8'h5E, 8'hFB, 8'h35, 8'h59};
   int          miscompares = 0, tests_run = 0, i, n, k, m;

   sltpg_gen uut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .link_mode_index(link_mode_index),
      .test_sel(test_sel), .enc_8b10b(enc_8b10b), .ila_len(ila_len), .sync_req(sync_req),
      .sample_data(sample_data), .lane_data(lane_data), .lane_is_ctrl(lane_is_ctrl),
      .link_state(link_state), .active_test(active_test));
   sltpg_rx_model rx (.core_clk(core_clk), .rst_b(rst_b), .want_sync(want_sync), .sync_req(sync_req));

   always #25 core_clk = ~core_clk;

   // ==========================
   // helpers
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task chk(input logic [63:0] a, input logic [63:0] b);
      tests_run++;
      if (a !== b)
      begin
         miscompares++;
         $display("MISMATCH t=%0t got %h exp %h", $time, a, b);
      end
   endtask
   task step;
      @(posedge core_clk);
      #1;
   endtask
   task tally_and_finish;
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task set_test(input sltpg_test_e t, input logic [3:0] md);
      link_mode_index = md;
      test_sel = t;
      for (k = 0; k < 8 && active_test !== t; k++)
         step;
      `CHK(active_test, t);
      step;
   endtask
   // waits for the first octet of the frame, then checks three whole frames
   task check_frames(input int len);
      for (k = 0; k < 16 && lane_data[7:0] !== frm[0][0]; k++)
         step;
      for (n = 0; n < 3 * len; n++)
      begin
         for (i = 0; i < 8; i++)
            `CHK(lane_data[8*i +: 8], frm[i][n % len]);
         step;
      end
   endtask
   task fill(input logic [7:0] v);
      for (i = 0; i < 8; i++)
         frm[i] = '{v};
   endtask
   // random samples must appear one cycle later, untouched
   task pass_run;
      repeat (20)
      begin
         lfsr = lfsr_next(lfsr);
         sample_data = {lfsr, ~lfsr};
         prev = sample_data;
         step;
         `CHK(lane_data, prev);
      end
   endtask

   // ==========================
   // main sequence
   initial
   begin
      repeat (10) @(posedge core_clk);
      #1 rst_b = 1;
      step;
      pass_run;
      // a low enable freezes output and select alike
      clk_en = 0;
      test_sel = SLTPG_D21_5;
      sample_data = ~prev;
      repeat (3) step;
      `CHK(lane_data, prev);
      `CHK(active_test, SLTPG_NORMAL);
      clk_en = 1;
      for (i = 0; i < 8; i++)
         frm[i] = '{8'(i < 4 ? i + 1 : 'h0D + i)};
      set_test(SLTPG_SHORT_TP, 4'h000C);
      check_frames(1);
      for (m = 14; m < 16; m++)
      begin
         for (i = 0; i < 8; i++)
         begin
            w = 12'hF01 - 12'(i) * 12'h0F0;
            frm[i] = '{w[11:4], {w[3:0], 4'hF & 4'(w[11:8])}, 8'(w[7:0] + 1)};
         end
         set_test(SLTPG_SHORT_TP, 4'(m));
         check_frames(3);
      end
      // mode 13: four ten-bit words per lane, first word high, over five octets
      for (i = 0; i < 8; i++)
      begin
         f40 = '0;
         for (n = 0; n < 4; n++)
            f40 = {f40[29:0], 10'((i < 4 ? 'h301 : 'h341) - (i % 4) * 'hF0 + n)};
         frm[i] = '{f40[39:32], f40[31:24], f40[23:16], f40[15:8], f40[7:0]};
      end
      set_test(SLTPG_SHORT_TP, 4'h000D);
      check_frames(5);
      for (m = 0; m < 2; m++)
      begin
         enc_8b10b = m[0];
         fill(8'hB5);
         set_test(SLTPG_D21_5, 4'h000C);
         check_frames(1);
         `CHK(lane_is_ctrl, 8'h00);
      end
      enc_8b10b = 1;
      fill(8'hBC);
      set_test(SLTPG_K28_5, 4'h000C);
      check_frames(1);
      `CHK(lane_is_ctrl, 8'hFF);
      enc_8b10b = 0;
      pass_run;
      `CHK(lane_is_ctrl, 8'h00);
      enc_8b10b = 1;
      for (i = 0; i < 8; i++)
         frm[i] = rpat;
      set_test(SLTPG_RPAT, 4'h000C);
      check_frames(12);
      enc_8b10b = 0;
      pass_run;
      enc_8b10b = 1;
      set_test(SLTPG_REP_ILA, 4'h000E);
      for (m = 0; m < 2; m++)
      begin
         ila_len = m[0] ? 4'h0003 : 4'h0000;
         want_sync = 1;
         repeat (4) step;
         `CHK(link_state, SLTPG_CGS);
         `CHK(lane_is_ctrl, 8'hFF);
         `CHK(lane_data, {8{8'hBC}});
         want_sync = 0;
         for (k = 0; k < 10 && link_state !== SLTPG_ILA; k++)
            step;
         `CHK(link_state, SLTPG_ILA);
         n = 0;
         repeat (60)
         begin
            step;
            n += (link_state === SLTPG_DATA);
         end
         `CHK(n, 0);
         `CHK(lane_is_ctrl, 8'h00);
      end
      // a second reset in mid-run returns to idle
      rst_b = 0;
      step;
      `CHK(active_test, SLTPG_NORMAL);
      `CHK(lane_data, 64'h0);
      `CHK(link_state, SLTPG_CGS);
      rst_b = 1;
      step;
      `CHK(lane_data, sample_data);
      `CHK(active_test, SLTPG_NORMAL);
      tally_and_finish;
   end

   initial
   begin
      #1_000_000;
      miscompares++;
      tally_and_finish;
   end
endmodule // serial_link_test_pattern_gen_tb
